// ---- esc_counter.sv ----
// one statistics counter: wrap or saturate, clear on demand, halfway pulse
`timescale 1ns/1ps
module esc_counter #(
  parameter int W = 8,
  parameter int IW = 1,
  parameter bit SAT = 1'b0
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic inc_en,
  input wire logic [IW-1:0] inc_amt,
  input wire logic clr,
  // state
  output logic [W-1:0] count_r,
  output logic half_r
);
  logic [W:0] sum;
  logic [W-1:0] count_nxt;

  always_comb begin
    sum = {1'b0, count_r} + (W+1)'(inc_amt);
    count_nxt = count_r;
    if (clr) begin
      // an event in the clearing cycle is kept, not lost
      count_nxt = inc_en ? W'(inc_amt) : '0;
    end else if (inc_en) begin
      if (SAT && sum[W]) begin
        count_nxt = '1;
      end else begin
        count_nxt = sum[W-1:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  // crossing of the top bit marks counting through half scale
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      half_r <= 1'b0;
    end else begin
      half_r <= inc_en && !clr && !count_r[W-1] && count_nxt[W-1];
    end
  end
endmodule

// ---- esc_pkg.sv ----
// constants shared by the ethernet statistics counter bank
package esc_pkg;
  // ***************************************************************
  // register indices, byte address is four times the index
  // ***************************************************************
  localparam logic [5:0] IDX_SQE_ERR = 6'h01;
  localparam logic [5:0] IDX_MULTI_COLL = 6'h02;
  localparam logic [5:0] IDX_ONE_COLL = 6'h03;
  localparam logic [5:0] IDX_LATE_COLL = 6'h04;
  localparam logic [5:0] IDX_RX_OVERRUN = 6'h05;
  localparam logic [5:0] IDX_TX_FRAMES_LO = 6'h06;
  localparam logic [5:0] IDX_RX_FRAMES_LO = 6'h07;
  localparam logic [5:0] IDX_FRAME_HI = 6'h09;
  localparam logic [5:0] IDX_RX_BYTES_LO = 6'h0a;
  localparam logic [5:0] IDX_TX_BYTES_LO = 6'h0c;
  localparam logic [5:0] IDX_BYTE_HI = 6'h0d;
  localparam logic [5:0] IDX_CONTROL = 6'h10;
  localparam logic [5:0] IDX_EVENT = 6'h11;
  localparam int ADDR_W = 8;
  localparam int IDX_LSB = 2;

  // ***************************************************************
  // widths
  // ***************************************************************
  localparam int FRAME_W = 10;
  localparam int BYTE_W = 20;
  localparam int SMALL_W = 8;
  localparam int SQE_W = 4;
  localparam int LEN_W = 16;
  localparam int COLL_W = 5;
  localparam int NUM_SMALL = 4;

  // ***************************************************************
  // field positions and reset values
  // ***************************************************************
  localparam int CTL_STATS_ON = 0;
  localparam int CTL_SQE_EN = 1;
  localparam int EVT_UPDATE = 0;
  localparam logic CTL_STATS_ON_RST = 1'b0;
  localparam logic CTL_SQE_EN_RST = 1'b1;
  localparam logic [4:0] COLL_ONE = 5'h01;
  localparam logic [4:0] COLL_MULTI_MIN = 5'h02;
  localparam logic [4:0] COLL_MULTI_MAX = 5'h0f;

  // ***************************************************************
  // axi responses
  // ***************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // small counter slots inside the generate loop
  typedef enum logic [1:0] {
    ESC_SLOT_LATE = 2'h0,
    ESC_SLOT_MULTI = 2'h1,
    ESC_SLOT_ONE = 2'h2,
    ESC_SLOT_OVERRUN = 2'h3
  } esc_slot_t;
endpackage

// ---- esc_stats.sv ----
// ethernet statistics counter bank behind an axi4-lite slave
// How it works
// R1: received frames count good only when no upload error flag is set
// R2: good-frame counters are 10 bits, wrap, flag update at 200h crossing
// R3: reading rx frame count latches its two top bits into latch bits 1:0
// R4: reading tx frame count latches its two top bits into latch bits 5:4
// R5: reading the frame high latch leaves its contents untouched
// R6: transmitted frames good unless excess collision, babble or starved flagged
// R7: every late collision adds one, several per frame possible
// R8: multi-collision count adds once per good frame with 2..15 collisions
// R9: single-collision count adds once per good frame with one collision
// R10: overruns count only after reception began, not full-at-start drops
// R11: 8-bit counters wrap and flag update at 80h crossing
// R12: sqe counter 4 bits, saturates at 0fh, flags at 08h, top bits zero
// R13: sqe counting has its own enable in the media state register
// R14: reading a collision, overrun or sqe counter clears it
// R15: no counter moves until the statistics-on command is given
// R16: byte counters 20 bits, low read latches top nibble into byte latch
// R17: the byte high latch clears on reset
// R18: software reads each 16-bit byte count in one access
// R19: all half crossings merge into one sticky update flag
// R20: frame latch bits 3:2 and 7:6 read as zero
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module esc_stats (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [esc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [esc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // receive status events, one-cycle pulses
  input wire logic rx_frame_done,
  input wire logic [esc_pkg::LEN_W-1:0] rx_frame_len,
  input wire logic upload_overrun_flag,
  input wire logic upload_short_frame_flag,
  input wire logic upload_align_error_flag,
  input wire logic upload_checksum_error_flag,
  input wire logic upload_long_frame_flag,
  input wire logic receive_overflow_error,
  input wire logic rx_frame_started,
  // transmit status events, one-cycle pulses
  input wire logic tx_frame_done,
  input wire logic [esc_pkg::LEN_W-1:0] tx_frame_len,
  input wire logic [esc_pkg::COLL_W-1:0] tx_collision_count,
  input wire logic excess_collision_flag,
  input wire logic transmit_babble_flag,
  input wire logic transmit_starved_flag,
  input wire logic late_collision_pulse,
  input wire logic sqe_error_pulse,
  // indication
  output logic stats_update_event
);
  // ***************************************************************
  // register bus state
  // ***************************************************************
  logic aw_got_r;
  logic w_got_r;
  logic [esc_pkg::ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic ar_take;
  logic wr_fire;
  logic [5:0] rd_idx;
  logic [5:0] wr_idx;

  // ***************************************************************
  // control and counter state
  // ***************************************************************
  logic stats_on_command;
  logic sqe_count_enable;
  logic update_r;
  logic [1:0] rx_frame_high_bits;
  logic [1:0] tx_frame_high_bits;
  logic [3:0] rx_byte_high_nibble;
  logic [3:0] tx_byte_high_nibble;
  logic [esc_pkg::FRAME_W-1:0] rx_frames;
  logic [esc_pkg::FRAME_W-1:0] tx_frames;
  logic [esc_pkg::BYTE_W-1:0] good_rx_byte_count;
  logic [esc_pkg::BYTE_W-1:0] good_tx_byte_count;
  logic [esc_pkg::SQE_W-1:0] sqe_error_count;
  logic [esc_pkg::SMALL_W-1:0] small_cnt [esc_pkg::NUM_SMALL];
  logic [esc_pkg::NUM_SMALL-1:0] small_inc;
  logic [esc_pkg::NUM_SMALL-1:0] small_clr;
  logic [esc_pkg::NUM_SMALL-1:0] small_half;
  logic rx_frm_half;
  logic tx_frm_half;
  logic rx_byt_half;
  logic tx_byt_half;
  logic sqe_half;
  logic rx_good;
  logic tx_good;
  logic any_half;
  logic rd_rx_frames;
  logic rd_tx_frames;
  logic rd_rx_bytes;
  logic rd_tx_bytes;
  logic rd_sqe;
  logic evt_clear;

  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign wr_fire = aw_got_r && w_got_r && !bvalid_r;
  assign rd_idx = s_axi_araddr[esc_pkg::IDX_LSB +: 6];
  assign wr_idx = awaddr_r[esc_pkg::IDX_LSB +: 6];

  // ***************************************************************
  // event qualification
  // ***************************************************************
  // R1: any upload error disqualifies
  assign rx_good = rx_frame_done && !(upload_overrun_flag || upload_short_frame_flag ||
                   upload_align_error_flag || upload_checksum_error_flag ||
                   upload_long_frame_flag);
  // R6: transmit errors disqualify
  assign tx_good = tx_frame_done && !(excess_collision_flag || transmit_babble_flag ||
                   transmit_starved_flag);

  // R15: counters held until enabled
  always_comb begin
    small_inc = '0;
    if (stats_on_command) begin
      // R7: each late collision counts
      small_inc[esc_pkg::ESC_SLOT_LATE] = late_collision_pulse;
      // R8: good frame, 2..15 collisions
      small_inc[esc_pkg::ESC_SLOT_MULTI] = tx_good &&
        (tx_collision_count >= esc_pkg::COLL_MULTI_MIN) &&
        (tx_collision_count <= esc_pkg::COLL_MULTI_MAX);
      // R9: good frame, exactly one
      small_inc[esc_pkg::ESC_SLOT_ONE] = tx_good && (tx_collision_count == esc_pkg::COLL_ONE);
      // R10: only overruns after frame start
      small_inc[esc_pkg::ESC_SLOT_OVERRUN] = receive_overflow_error && rx_frame_started;
    end
  end

  // ***************************************************************
  // read-side strobes
  // ***************************************************************
  assign rd_rx_frames = ar_take && (rd_idx == esc_pkg::IDX_RX_FRAMES_LO);
  assign rd_tx_frames = ar_take && (rd_idx == esc_pkg::IDX_TX_FRAMES_LO);
  assign rd_rx_bytes = ar_take && (rd_idx == esc_pkg::IDX_RX_BYTES_LO);
  assign rd_tx_bytes = ar_take && (rd_idx == esc_pkg::IDX_TX_BYTES_LO);
  assign rd_sqe = ar_take && (rd_idx == esc_pkg::IDX_SQE_ERR);

  // R14: collision and overrun reads clear
  always_comb begin
    small_clr = '0;
    small_clr[esc_pkg::ESC_SLOT_LATE] = ar_take && (rd_idx == esc_pkg::IDX_LATE_COLL);
    small_clr[esc_pkg::ESC_SLOT_MULTI] = ar_take && (rd_idx == esc_pkg::IDX_MULTI_COLL);
    small_clr[esc_pkg::ESC_SLOT_ONE] = ar_take && (rd_idx == esc_pkg::IDX_ONE_COLL);
    small_clr[esc_pkg::ESC_SLOT_OVERRUN] = ar_take && (rd_idx == esc_pkg::IDX_RX_OVERRUN);
  end

  // ***************************************************************
  // counters
  // ***************************************************************
  // R11: four wrapping 8-bit counters
  for (genvar i = 0; i < esc_pkg::NUM_SMALL; i++) begin : g_small
    esc_counter #(.W(esc_pkg::SMALL_W), .IW(1), .SAT(1'b0)) u_cnt (
      .aclk(aclk),
      .aresetn(aresetn),
      .inc_en(small_inc[i]),
      .inc_amt(1'b1),
      .clr(small_clr[i]),
      .count_r(small_cnt[i]),
      .half_r(small_half[i])
    );
  end

  // R2: 10-bit good-frame counters, kept across reads
  esc_counter #(.W(esc_pkg::FRAME_W), .IW(1), .SAT(1'b0)) u_rx_frm (
    .aclk(aclk),
    .aresetn(aresetn),
    .inc_en(stats_on_command && rx_good),
    .inc_amt(1'b1),
    .clr(1'b0),
    .count_r(rx_frames),
    .half_r(rx_frm_half)
  );

  esc_counter #(.W(esc_pkg::FRAME_W), .IW(1), .SAT(1'b0)) u_tx_frm (
    .aclk(aclk),
    .aresetn(aresetn),
    .inc_en(stats_on_command && tx_good),
    .inc_amt(1'b1),
    .clr(1'b0),
    .count_r(tx_frames),
    .half_r(tx_frm_half)
  );

  // R16: 20-bit byte counters, cleared by their low read
  esc_counter #(.W(esc_pkg::BYTE_W), .IW(esc_pkg::LEN_W), .SAT(1'b0)) u_rx_byt (
    .aclk(aclk),
    .aresetn(aresetn),
    .inc_en(stats_on_command && rx_good),
    .inc_amt(rx_frame_len),
    .clr(rd_rx_bytes),
    .count_r(good_rx_byte_count),
    .half_r(rx_byt_half)
  );

  esc_counter #(.W(esc_pkg::BYTE_W), .IW(esc_pkg::LEN_W), .SAT(1'b0)) u_tx_byt (
    .aclk(aclk),
    .aresetn(aresetn),
    .inc_en(stats_on_command && tx_good),
    .inc_amt(tx_frame_len),
    .clr(rd_tx_bytes),
    .count_r(good_tx_byte_count),
    .half_r(tx_byt_half)
  );

  // R12: saturating 4-bit sqe counter
  // R13: own enable gates it
  esc_counter #(.W(esc_pkg::SQE_W), .IW(1), .SAT(1'b1)) u_sqe (
    .aclk(aclk),
    .aresetn(aresetn),
    .inc_en(stats_on_command && sqe_count_enable && sqe_error_pulse),
    .inc_amt(1'b1),
    .clr(rd_sqe),
    .count_r(sqe_error_count),
    .half_r(sqe_half)
  );

  // ***************************************************************
  // high-bit latches
  // ***************************************************************
  // R3: rx frame read latches bits 9:8
  // R4: tx frame read latches bits 9:8
  // R5: only counter reads touch the latch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_frame_high_bits <= '0;
      tx_frame_high_bits <= '0;
    end else begin
      if (rd_rx_frames) begin
        rx_frame_high_bits <= rx_frames[esc_pkg::FRAME_W-1 -: 2];
      end
      if (rd_tx_frames) begin
        tx_frame_high_bits <= tx_frames[esc_pkg::FRAME_W-1 -: 2];
      end
    end
  end

  // R16: byte read latches top nibble
  // R17: latch cleared by reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_byte_high_nibble <= '0;
      tx_byte_high_nibble <= '0;
    end else begin
      if (rd_rx_bytes) begin
        rx_byte_high_nibble <= good_rx_byte_count[esc_pkg::BYTE_W-1 -: 4];
      end
      if (rd_tx_bytes) begin
        tx_byte_high_nibble <= good_tx_byte_count[esc_pkg::BYTE_W-1 -: 4];
      end
    end
  end

  // ***************************************************************
  // update flag and control register
  // ***************************************************************
  assign any_half = (|small_half) || rx_frm_half || tx_frm_half || rx_byt_half ||
                    tx_byt_half || sqe_half;
  assign evt_clear = wr_fire && (wr_idx == esc_pkg::IDX_EVENT) && wstrb_r[0] &&
                     wdata_r[esc_pkg::EVT_UPDATE];

  // R19: sticky, set beats write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      update_r <= 1'b0;
      stats_update_event <= 1'b0;
    end else begin
      update_r <= any_half || (update_r && !evt_clear);
      stats_update_event <= any_half || (update_r && !evt_clear);
    end
  end

  // R15: statistics-on command bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stats_on_command <= esc_pkg::CTL_STATS_ON_RST;
      sqe_count_enable <= esc_pkg::CTL_SQE_EN_RST;
    end else if (wr_fire && (wr_idx == esc_pkg::IDX_CONTROL) && wstrb_r[0]) begin
      stats_on_command <= wdata_r[esc_pkg::CTL_STATS_ON];
      sqe_count_enable <= wdata_r[esc_pkg::CTL_SQE_EN];
    end
  end

  // ***************************************************************
  // axi4-lite write channel
  // ***************************************************************
  // address and data taken in either order, one write at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_got_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_got_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_got_r && !(s_axi_awvalid && s_axi_awready) && !bvalid_r;
      s_axi_wready <= !w_got_r && !(s_axi_wvalid && s_axi_wready) && !bvalid_r;
    end
  end

  // counter locations accept writes silently; holes answer decerr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= esc_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      case (wr_idx)
        esc_pkg::IDX_SQE_ERR, esc_pkg::IDX_MULTI_COLL, esc_pkg::IDX_ONE_COLL,
        esc_pkg::IDX_LATE_COLL, esc_pkg::IDX_RX_OVERRUN, esc_pkg::IDX_TX_FRAMES_LO,
        esc_pkg::IDX_RX_FRAMES_LO, esc_pkg::IDX_FRAME_HI, esc_pkg::IDX_RX_BYTES_LO,
        esc_pkg::IDX_TX_BYTES_LO, esc_pkg::IDX_BYTE_HI, esc_pkg::IDX_CONTROL,
        esc_pkg::IDX_EVENT: begin
          bresp_r <= esc_pkg::RESP_OKAY;
        end
        default: begin
          bresp_r <= esc_pkg::RESP_DECERR;
        end
      endcase
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // ***************************************************************
  // axi4-lite read channel
  // ***************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !rvalid_r && !ar_take;
    end
  end

  // data sampled before the clear lands in the same edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= esc_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rresp_r <= esc_pkg::RESP_OKAY;
      rdata_r <= '0;
      case (rd_idx)
        esc_pkg::IDX_SQE_ERR: begin
          // R12: upper four bits read zero
          rdata_r[esc_pkg::SQE_W-1:0] <= sqe_error_count;
        end
        esc_pkg::IDX_MULTI_COLL: begin
          rdata_r[esc_pkg::SMALL_W-1:0] <= small_cnt[esc_pkg::ESC_SLOT_MULTI];
        end
        esc_pkg::IDX_ONE_COLL: begin
          rdata_r[esc_pkg::SMALL_W-1:0] <= small_cnt[esc_pkg::ESC_SLOT_ONE];
        end
        esc_pkg::IDX_LATE_COLL: begin
          rdata_r[esc_pkg::SMALL_W-1:0] <= small_cnt[esc_pkg::ESC_SLOT_LATE];
        end
        esc_pkg::IDX_RX_OVERRUN: begin
          rdata_r[esc_pkg::SMALL_W-1:0] <= small_cnt[esc_pkg::ESC_SLOT_OVERRUN];
        end
        esc_pkg::IDX_TX_FRAMES_LO: begin
          rdata_r[esc_pkg::SMALL_W-1:0] <= tx_frames[esc_pkg::SMALL_W-1:0];
        end
        esc_pkg::IDX_RX_FRAMES_LO: begin
          rdata_r[esc_pkg::SMALL_W-1:0] <= rx_frames[esc_pkg::SMALL_W-1:0];
        end
        esc_pkg::IDX_FRAME_HI: begin
          // R20: gaps stay zero
          rdata_r[7:0] <= {2'h0, tx_frame_high_bits, 2'h0, rx_frame_high_bits};
        end
        esc_pkg::IDX_RX_BYTES_LO: begin
          // R18: whole low half in one read
          rdata_r[esc_pkg::LEN_W-1:0] <= good_rx_byte_count[esc_pkg::LEN_W-1:0];
        end
        esc_pkg::IDX_TX_BYTES_LO: begin
          rdata_r[esc_pkg::LEN_W-1:0] <= good_tx_byte_count[esc_pkg::LEN_W-1:0];
        end
        esc_pkg::IDX_BYTE_HI: begin
          rdata_r[7:0] <= {tx_byte_high_nibble, rx_byte_high_nibble};
        end
        esc_pkg::IDX_CONTROL: begin
          rdata_r[esc_pkg::CTL_STATS_ON] <= stats_on_command;
          rdata_r[esc_pkg::CTL_SQE_EN] <= sqe_count_enable;
        end
        esc_pkg::IDX_EVENT: begin
          rdata_r[esc_pkg::EVT_UPDATE] <= update_r;
        end
        default: begin
          rresp_r <= esc_pkg::RESP_DECERR;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
endmodule

// ---- esc_stats_monitor.sv ----
// concurrent checks on the statistics counter bank ports
`timescale 1ns/1ps
module esc_stats_monitor (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus
  input wire logic [esc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // indication
  input wire logic stats_update_event
);
  // index of the read in flight, so read data can be judged by place
  logic [5:0] idx_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) idx_r <= 6'h00;
    else if (s_axi_arvalid && s_axi_arready) idx_r <= s_axi_araddr[7:2];
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ar_take; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_r_wait; s_axi_rvalid && !s_axi_rready; endsequence
  property p_rd_lat; s_ar_take |=> s_axi_rvalid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_r_hold; s_r_wait |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_b_hold; s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_ar_refuse; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_refuse: assert property (p_ar_refuse) else $error("read taken early");
  property p_sqe_top; s_axi_rvalid && idx_r == 6'h01 |-> s_axi_rdata[31:4] == 28'h0; endproperty
  a_sqe_top: assert property (p_sqe_top) else $error("sqe top bits set");
  property p_frame_pad; s_axi_rvalid && idx_r == 6'h09 |-> s_axi_rdata[7:6] == 2'h0
    && s_axi_rdata[3:2] == 2'h0; endproperty
  a_frame_pad: assert property (p_frame_pad) else $error("latch pad bits set");
  // no write in flight, so the flag must stay
  property p_sticky; stats_update_event && s_axi_awready && !s_axi_awvalid
    |=> stats_update_event; endproperty
  a_sticky: assert property (p_sticky) else $error("update flag lost");
  property p_decerr; s_axi_rvalid && !(idx_r inside {[6'h01:6'h07], 6'h09, 6'h0a, 6'h0c,
    6'h0d, 6'h10, 6'h11}) |-> s_axi_rresp == esc_pkg::RESP_DECERR && s_axi_rdata == 32'h0;
  endproperty
  a_decerr: assert property (p_decerr) else $error("unmapped read answered");
endmodule
bind esc_stats esc_stats_monitor u_mon (.*);

// ---- tb.sv ----
// self-checking bench for the statistics counter bank
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0;
  // rx done, tx done, late, sqe, overflow
  logic [4:0] ev = 5'h00, rxerr = 5'h00, coll = 5'h00;
  logic [2:0] txerr = 3'h0;
  logic [15:0] rxlen = 16'h0, txlen = 16'h0;
  logic started = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, upd;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata;
  logic [4:0] cl[5] = '{5'h00, 5'h01, 5'h02, 5'h0f, 5'h10};
  int num_errors = 0;
  int checked = 0;
  esc_stats DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .rx_frame_done(ev[0]), .rx_frame_len(rxlen),
    .upload_overrun_flag(rxerr[0]), .upload_short_frame_flag(rxerr[1]),
    .upload_align_error_flag(rxerr[2]), .upload_checksum_error_flag(rxerr[3]),
    .upload_long_frame_flag(rxerr[4]), .receive_overflow_error(ev[4]),
    .rx_frame_started(started), .tx_frame_done(ev[1]), .tx_frame_len(txlen),
    .tx_collision_count(coll), .excess_collision_flag(txerr[0]),
    .transmit_babble_flag(txerr[1]), .transmit_starved_flag(txerr[2]),
    .late_collision_pulse(ev[2]), .sqe_error_pulse(ev[3]), .stats_update_event(upd));
  initial begin
    forever #20 aclk = ~aclk;
  end
  // ***************************************************************
  // bus and event tasks
  // ***************************************************************
  // readies are registered, so sampling them at the falling edge is race free
  task automatic rc(input logic [5:0] i, input logic [31:0] e);
    @(posedge aclk);
    araddr <= {i, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'h0;
    do @(negedge aclk); while (!rvalid);
    r = rresp;
    `CHK(rdata, e)
    @(posedge aclk);
    rready <= 1'h0;
  endtask
  task automatic wr(input logic [5:0] i, input logic [31:0] v);
    logic ta, tw;
    @(posedge aclk);
    awaddr <= {i, 2'h0};
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    #1;
    while (awvalid || wvalid) begin
      @(negedge aclk);
      ta = awready;
      tw = wready;
      @(posedge aclk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
      #1;
    end
    do @(negedge aclk); while (!bvalid);
    `CHK(bresp, esc_pkg::RESP_OKAY)
    @(posedge aclk);
    bready <= 1'h0;
  endtask
  // one event per edge while held, so n edges give n counts
  task automatic pulse(input int b, input int n);
    @(posedge aclk);
    ev[b] <= 1'h1;
    repeat (n) @(posedge aclk);
    ev[b] <= 1'h0;
  endtask
  // ***************************************************************
  // scenarios
  // ***************************************************************
  task t_start;
    rc(6'h09, 32'h0);
    rc(6'h0d, 32'h0);
    rc(6'h08, 32'h0);
    `CHK(r, esc_pkg::RESP_DECERR)
    pulse(0, 3);
    pulse(2, 2);
    rc(6'h07, 32'h0);
    rc(6'h04, 32'h0);
    wr(6'h10, 32'h3);
    $display("test start done");
  endtask
  task t_rxtx;
    for (int k = 0; k < 5; k++) begin
      rxerr <= 5'(1 << k);
      rxlen <= 16'h9000;
      pulse(0, 1);
    end
    rxerr <= 5'h00;
    pulse(0, 2);
    rc(6'h07, 32'h2);
    rc(6'h0a, 32'h2000);
    rc(6'h0d, 32'h1);
    rc(6'h0a, 32'h0);
    for (int k = 0; k < 3; k++) begin
      txerr <= 3'(1 << k);
      coll <= 5'h02;
      txlen <= 16'h4000;
      pulse(1, 1);
    end
    txerr <= 3'h0;
    for (int k = 0; k < 5; k++) begin
      coll <= cl[k];
      pulse(1, 1);
    end
    rc(6'h06, 32'h5);
    rc(6'h03, 32'h1);
    rc(6'h02, 32'h2);
    rc(6'h02, 32'h0);
    rc(6'h0c, 32'h4000);
    rc(6'h0d, 32'h10);
    $display("test rxtx done");
  endtask
  task t_small;
    @(negedge aclk);
    `CHK(upd, 1'h0)
    pulse(2, 128);
    repeat (3) @(negedge aclk);
    `CHK(upd, 1'h1)
    rc(6'h04, 32'h80);
    rc(6'h04, 32'h0);
    wr(6'h11, 32'h1);
    @(negedge aclk);
    `CHK(upd, 1'h0)
    pulse(4, 2);
    started <= 1'h1;
    pulse(4, 3);
    rc(6'h05, 32'h3);
    pulse(3, 20);
    rc(6'h01, 32'hf);
    wr(6'h10, 32'h1);
    pulse(3, 4);
    rc(6'h01, 32'h0);
    $display("test small done");
  endtask
  task t_frames;
    rxlen <= 16'h0;
    txlen <= 16'h0;
    coll <= 5'h00;
    pulse(0, 511);
    rc(6'h07, 32'h1);
    rc(6'h09, 32'h2);
    rc(6'h09, 32'h2);
    pulse(0, 511);
    rc(6'h09, 32'h2);
    rc(6'h07, 32'h0);
    pulse(1, 507);
    rc(6'h06, 32'h0);
    rc(6'h09, 32'h20);
    $display("test frames done");
  endtask
  task give_verdict;
    $display("checked=%0d num_errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    t_start;
    t_rxtx;
    t_small;
    t_frames;
    give_verdict;
  end
  // about 1900 cycles expected, so this bound only trips on a hang
  initial begin
    repeat (12000) @(posedge aclk);
    num_errors++;
    give_verdict;
  end
endmodule
